// *** inc/ptt_regs.vh ***
// constants for the periodic tick timer: offsets, fields, resets, timing
// assumes a 32-bit AHB-Lite slave with word registers at byte offsets
//
// Behaviour
// RULE1: the timer has a 20-bit interval counter and a separate 12-bit interval tally.
// RULE2: both counters advance on a tick made from the main clock divided by sixteen.
// RULE3: the counter counts up from zero and at the limit returns to zero and bumps the tally.
// RULE4: reaching the limit sets the interval flag, which drives the interrupt only when enabled.
// RULE5: writing a new limit restarts nothing and only affects later comparisons.
// RULE6: reading the value register returns counter and tally, then clears tally and flag.
// RULE7: reading the image register returns the same contents with no side effect.
// RULE8: the timer resets disabled and an enable change takes effect only while the counter is zero.
// RULE9: once disabled the counter runs on to the limit, returns to zero and holds there.
// RULE10: both counters halt while the core is in debug state.
// RULE11: the mode register holds the limit in bits 19..0, enable at 24, interrupt enable at 25.
// RULE12: with interrupt enable low the flag cannot reach the interrupt; with it high it does. The code also needs mask bit 0 at 0x010 set.
// RULE13: the flag sits at status bit 0 and stays set until the next clearing value read.
// RULE14: the tally reports intervals completed since the previous clearing value read.
// RULE15: value and image registers carry the tally in bits 31..20 and the counter in 19..0.
// RULE16: the tally wraps modulo its width when more intervals elapse than it can hold.
`ifndef PTT_REGS_VH
`define PTT_REGS_VH

`define PTT_OFS_MODE 12'h000
`define PTT_OFS_STATUS 12'h004
`define PTT_OFS_VALUE_ACK 12'h008
`define PTT_OFS_VALUE_PEEK 12'h00c
`define PTT_OFS_IRQ_MASK 12'h010

`define PTT_MODE_RESET 32'h000fffff
`define PTT_LIMIT_MSB 19
`define PTT_TIMER_ON_BIT 24
`define PTT_FLAG_IRQ_ON_BIT 25
`define PTT_FLAG_BIT 0
`define PTT_TALLY_LSB 20

`define PTT_DIV_RATIO 16

`endif

// *** hdl/ptt_periodic_tick_timer.v ***
// periodic tick timer: 20-bit interval counter plus 12-bit interval tally
// assumes a single AHB-Lite master, hclk at 20 MHz, debug_halt synchronous to hclk
// mode 0x000, status 0x004, value 0x008, image 0x00c, interrupt mask 0x010
// debug_halt freezes divider and counters; irq is a level output
`timescale 1ns/10ps
`include "ptt_regs.vh"

module ptt_periodic_tick_timer
#(
  parameter CNT_W = 20,
  parameter TALLY_W = 12,
  parameter DIV_RATIO = `PTT_DIV_RATIO
)
(
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire debug_halt,
  output wire irq
);

  ////////////////////////////////////////////////////////////////////////
  // constants and helpers

  localparam [31:0] MODE_RST = `PTT_MODE_RESET;
  localparam [11:0] OFS_MODE = `PTT_OFS_MODE;
  localparam [11:0] OFS_STATUS = `PTT_OFS_STATUS;
  localparam [11:0] OFS_VALUE_ACK = `PTT_OFS_VALUE_ACK;
  localparam [11:0] OFS_VALUE_PEEK = `PTT_OFS_VALUE_PEEK;
  localparam [11:0] OFS_IRQ_MASK = `PTT_OFS_IRQ_MASK;
  localparam [31:0] DIV_LAST_W = DIV_RATIO - 1;
  localparam [3:0] DIV_LAST = DIV_LAST_W[3:0];
  localparam [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};
  localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};
  localparam [TALLY_W-1:0] TALLY_ZERO = {TALLY_W{1'b0}};
  localparam [TALLY_W-1:0] TALLY_ONE = {{(TALLY_W-1){1'b0}}, 1'b1};

  // address compare on the low word offset
  function hit;
    input [11:0] a;
    input [11:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // read layout shared by the value and image registers
  function [31:0] pack_value;
    input [TALLY_W-1:0] t;
    input [CNT_W-1:0] c;
    begin
      pack_value = {t, c}; // RULE15
    end
  endfunction

  // mode register read layout
  function [31:0] pack_mode;
    input irq_on;
    input on;
    input [CNT_W-1:0] lim;
    begin
      pack_mode = {6'h00, irq_on, on, 4'h0, lim}; // RULE11
    end
  endfunction

  // one-bit registers read back in bit 0
  function [31:0] pack_status;
    input b;
    begin
      pack_status = {31'h00000000, b};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // bus address phase capture

  reg wr_pend_r;
  reg wr_pend_nxt;
  reg [11:0] wr_addr_r;
  reg [11:0] wr_addr_nxt;
  wire acc;
  wire rd_acc;
  wire [11:0] a_lo;

  assign acc = hsel & hready & htrans[1];
  assign rd_acc = acc & ~hwrite;
  assign a_lo = haddr[11:0];

  // write data arrives one cycle after its address
  always @*
  begin
    wr_pend_nxt = acc & hwrite;
    wr_addr_nxt = wr_addr_r;
    if (acc)
      wr_addr_nxt = a_lo;
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 12'h000;
    end
    else
    begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
    end
  end

  // zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // register decode

  wire wr_mode;
  wire wr_mask;
  wire rd_mode;
  wire rd_status;
  wire rd_ack;
  wire rd_peek;
  wire rd_mask;

  assign wr_mode = wr_pend_r & hit(wr_addr_r, OFS_MODE);
  assign wr_mask = wr_pend_r & hit(wr_addr_r, OFS_IRQ_MASK);
  assign rd_mode = rd_acc & hit(a_lo, OFS_MODE);
  assign rd_status = rd_acc & hit(a_lo, OFS_STATUS);
  // value read clears at its address edge
  assign rd_ack = rd_acc & hit(a_lo, OFS_VALUE_ACK); // RULE6
  assign rd_peek = rd_acc & hit(a_lo, OFS_VALUE_PEEK); // RULE7
  assign rd_mask = rd_acc & hit(a_lo, OFS_IRQ_MASK);

  ////////////////////////////////////////////////////////////////////////
  // mode and mask registers

  reg [CNT_W-1:0] limit_r;
  reg [CNT_W-1:0] limit_nxt;
  reg timer_on_r;
  reg timer_on_nxt;
  reg flag_irq_on_r;
  reg flag_irq_on_nxt;
  reg mask_r;
  reg mask_nxt;

  wire [CNT_W-1:0] wr_limit;
  wire wr_on;
  wire wr_irq_on;

  assign wr_limit = hwdata[`PTT_LIMIT_MSB:0];
  assign wr_on = hwdata[`PTT_TIMER_ON_BIT];
  assign wr_irq_on = hwdata[`PTT_FLAG_IRQ_ON_BIT];

  // a new limit never touches the counters
  always @*
  begin
    limit_nxt = limit_r;
    timer_on_nxt = timer_on_r;
    flag_irq_on_nxt = flag_irq_on_r;
    mask_nxt = mask_r;
    if (wr_mode)
    begin
      limit_nxt = wr_limit; // RULE11 RULE5
      timer_on_nxt = wr_on; // RULE11
      flag_irq_on_nxt = wr_irq_on; // RULE11
    end
    else if (wr_mask)
      mask_nxt = hwdata[0];
  end

  // mode reset leaves the timer off
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      limit_r <= MODE_RST[CNT_W-1:0];
      timer_on_r <= MODE_RST[`PTT_TIMER_ON_BIT]; // RULE8
      flag_irq_on_r <= MODE_RST[`PTT_FLAG_IRQ_ON_BIT];
      mask_r <= 1'b0;
    end
    else
    begin
      limit_r <= limit_nxt;
      timer_on_r <= timer_on_nxt;
      flag_irq_on_r <= flag_irq_on_nxt;
      mask_r <= mask_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // main clock divider, frozen in debug state

  reg [3:0] div_r;
  reg [3:0] div_nxt;
  wire div_wrap;
  wire tick;

  // one tick per DIV_RATIO clocks while not halted
  assign div_wrap = (div_r == DIV_LAST);
  assign tick = div_wrap & ~debug_halt; // RULE2 RULE10

  always @*
  begin
    div_nxt = div_r;
    if (!debug_halt) // RULE10
    begin
      if (div_wrap)
        div_nxt = 4'h0; // RULE2
      else
        div_nxt = div_r + 4'h1;
    end
  end

  // divider free-runs from reset
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      div_r <= 4'h0;
    else
      div_r <= div_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // interval counter and run state

  reg run_r;
  reg run_nxt;
  reg [CNT_W-1:0] count_r;
  reg [CNT_W-1:0] count_nxt;
  wire at_zero;
  wire count_match;
  wire count_step;
  wire at_limit;

  // limit match only counts on a tick
  assign at_zero = (count_r == CNT_ZERO);
  assign count_match = (count_r == limit_r);
  assign count_step = tick & run_r;
  assign at_limit = count_step & count_match;

  // enable is taken only while the counter rests at zero
  always @*
  begin
    run_nxt = run_r;
    count_nxt = count_r;
    if (at_zero)
      run_nxt = timer_on_r; // RULE8
    if (at_limit)
    begin
      count_nxt = CNT_ZERO; // RULE3 RULE9
      if (!timer_on_r)
        run_nxt = 1'b0; // RULE9
    end
    else if (count_step)
      count_nxt = count_r + CNT_ONE; // RULE3 RULE1
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      run_r <= 1'b0;
      count_r <= CNT_ZERO;
    end
    else
    begin
      run_r <= run_nxt;
      count_r <= count_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interval tally and flag; a match in the clearing cycle wins

  reg [TALLY_W-1:0] tally_r;
  reg [TALLY_W-1:0] tally_nxt;
  reg flag_r;
  reg flag_nxt;

  // tally wraps modulo its width
  always @*
  begin
    tally_nxt = tally_r;
    flag_nxt = flag_r;
    if (at_limit)
    begin
      if (rd_ack)
        tally_nxt = TALLY_ONE; // RULE14
      else
        tally_nxt = tally_r + TALLY_ONE; // RULE3 RULE14 RULE16
      flag_nxt = 1'b1; // RULE4 RULE13
    end
    else if (rd_ack)
    begin
      tally_nxt = TALLY_ZERO; // RULE6
      flag_nxt = 1'b0; // RULE6 RULE13
    end
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tally_r <= TALLY_ZERO;
      flag_r <= 1'b0;
    end
    else
    begin
      tally_r <= tally_nxt;
      flag_r <= flag_nxt;
    end
  end

  // both enables gate the flag
  wire irq_src;
  assign irq_src = flag_r & flag_irq_on_r; // RULE12
  assign irq = irq_src & mask_r; // RULE4

  ////////////////////////////////////////////////////////////////////////
  // read data, captured at the address phase

  wire [31:0] mode_word;
  wire [31:0] status_word;
  wire [31:0] value_word;
  wire [31:0] mask_word;
  reg [31:0] rdata_nxt;

  assign mode_word = pack_mode(flag_irq_on_r, timer_on_r, limit_r); // RULE11
  assign status_word = pack_status(flag_r); // RULE13
  assign value_word = pack_value(tally_r, count_r); // RULE15
  assign mask_word = pack_status(mask_r);

  // unmapped offsets read as zero
  always @*
  begin
    rdata_nxt = hrdata;
    if (rd_acc)
    begin
      if (rd_mode)
        rdata_nxt = mode_word;
      else if (rd_status)
        rdata_nxt = status_word; // RULE13
      else if (rd_ack)
        rdata_nxt = value_word; // RULE6
      else if (rd_peek)
        rdata_nxt = value_word; // RULE7
      else if (rd_mask)
        rdata_nxt = mask_word;
      else
        rdata_nxt = 32'h00000000;
    end
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else
      hrdata <= rdata_nxt;
  end

endmodule

// *** test/ptt_checker.sv ***
// checker for the periodic tick timer
// sees only the timer's ports
`timescale 1ns/10ps
module ptt_checker (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  input wire debug_halt,
  input wire irq
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  wire rd = hsel && hready && htrans[1] && !hwrite;
  wire [11:0] a = haddr[11:0];
  wire pk = rd && a == 12'h00c;
  wire ak = rd && a == 12'h008;
  property p_ok; hreadyout && !hresp; endproperty
  a_ok: assert property (p_ok) else $error("not ready okay");
  property p_st; rd && a == 12'h004 |=> hrdata[31:1] == 0; endproperty
  a_st: assert property (p_st) else $error("status spare");
  property p_md; rd && a == 0 |=> hrdata[31:26] == 0 && hrdata[23:20] == 0; endproperty
  a_md: assert property (p_md) else $error("mode spare");
  property p_un; rd && a > 12'h010 |=> hrdata == 0; endproperty
  a_un: assert property (p_un) else $error("unmapped read");
  property p_tl; ak ##2 ak |=> hrdata[31:20] <= 1; endproperty
  a_tl: assert property (p_tl) else $error("tally kept");
  property p_ct; pk ##2 pk |=> hrdata[19:0] == $past(hrdata[19:0]) ||
    hrdata[19:0] == $past(hrdata[19:0]) + 20'h00001 || hrdata[19:0] == 20'h00000; endproperty
  a_ct: assert property (p_ct) else $error("count jump");
  property p_hl; pk && debug_halt ##1 debug_halt ##1 pk && debug_halt |=> $stable(hrdata); endproperty
  a_hl: assert property (p_hl) else $error("ran in halt");
  property p_iq; rd && a == 12'h004 |=> hrdata[0] || !$past(irq); endproperty
  a_iq: assert property (p_iq) else $error("irq without flag");
  c_irq: cover property (irq);
  c_hl: cover property (pk && debug_halt);
  c_ak: cover property (ak ##2 ak);
endmodule
bind ptt_periodic_tick_timer ptt_checker ptt_checker_i (.*);

// *** test/ptt_periodic_tick_timer_test.sv ***
// bench for the periodic tick timer
// drives its AHB-Lite port and debug_halt; mask at 0x010
`timescale 1ns/10ps
module ptt_periodic_tick_timer_test;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, debug_halt = 0;
  logic [31:0] haddr = 0, hwdata = 0, d, x;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 2;
  wire hready, hreadyout, hresp, irq;
  wire [31:0] hrdata;
  int num_errors = 0, total_checks = 0, n;
  assign hready = hreadyout;
  always #25 hclk = ~hclk;
  ptt_periodic_tick_timer ptt_periodic_tick_timer_i (.*);
  task summarize;
    $display("%0d errors %0d checks", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input string s, input [31:0] x, y);
    total_checks++;
    if (x !== y)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", s, x, y);
    end
  endtask
  // waits for irq or hready, bounded
  task wt(input bit w);
    @(posedge hclk);
    for (n = 1; n < 300 && (w ? irq : hready) !== 1'b1; n++)
      @(posedge hclk);
    if (n == 300)
    begin
      num_errors++;
      summarize;
    end
  endtask
  task xfer(input [31:0] a, w, input bit wr);
    hsel <= 1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    wt(0);
    htrans <= 2'h0;
    hwdata <= w;
    wt(0);
    d = hrdata;
  endtask
  task rc(input string s, input [31:0] a, x);
    xfer(a, 0, 0);
    chk(s, x, d);
  endtask
  task t_reset;
    rc("mode", 0, 32'h000fffff);
    rc("stat", 4, 0);
    rc("peek", 12, 0);
    rc("peek", 12, 0);
    rc("ack", 8, 0);
    rc("void", 32'h20, 0);
  endtask
  task t_tick;
    xfer(16, 1, 1);
    xfer(0, 32'h03000003, 1);
    wt(1);
    rc("peek", 12, 32'h00100000);
    rc("ack", 8, 32'h00100000);
    rc("stat", 4, 0);
    chk("irq", 0, irq);
    wt(1);
    chk("period", 64, n + 6);
    repeat (120) @(posedge hclk);
    rc("peek", 12, 32'h00200003);
  endtask
  task t_ctrl;
    xfer(0, 32'h01000003, 1);
    rc("stat", 4, 1);
    chk("irq", 0, irq);
    xfer(0, 3, 1);
    repeat (100) @(posedge hclk);
    xfer(8, 0, 0);
    rc("ack", 8, 0);
    xfer(0, 32'h01000003, 1);
    repeat (40) @(posedge hclk);
    debug_halt <= 1;
    xfer(12, 0, 0);
    rc("halt", 12, d);
    debug_halt <= 0;
  endtask
  task t_live;
    xfer(16, 0, 1);
    xfer(0, 32'h03000003, 1);
    repeat (80) @(posedge hclk);
    rc("stat", 4, 1);
    chk("irq", 0, irq);
    xfer(16, 1, 1);
    rc("stat", 4, 1);
    chk("irq", 1, irq);
    xfer(0, 32'h030000ff, 1);
    repeat (200) @(posedge hclk);
    xfer(12, 0, 0);
    x = d;
    xfer(0, 32'h030000fe, 1);
    xfer(12, 0, 0);
    chk("keep", 1, d[19:0] - x[19:0] <= 20'h00001 && d[19:0] > 20'h00000);
  endtask
  initial
  begin
    repeat (4) @(posedge hclk);
    hresetn <= 1;
    t_reset;
    t_tick;
    t_ctrl;
    t_live;
    summarize;
  end
endmodule
